// *** hw/ccp_consts.svh ***
// Offsets, field positions, reset values and codes of the capture/compare/PWM unit
`ifndef CCP_CONSTS_SVH
`define CCP_CONSTS_SVH
// Register word addresses (consecutive, one per register)
`define CCP_OFS_CONTROL_ONE_LOW 4'h0
`define CCP_OFS_OUTPUT_CONTROL_HIGH 4'h1
`define CCP_OFS_COMPARE_CONTROL_TWO 4'h2
`define CCP_OFS_PRIMARY_COMPARE 4'h3
`define CCP_OFS_SECONDARY_COMPARE 4'h4
`define CCP_OFS_STATUS 4'h5
`define CCP_OFS_CAPTURE 4'h6
`define CCP_OFS_TIMER 4'h7
// Field positions
`define CCP_MODE_LSB 0
`define CCP_CAPSEL_BIT 4
`define CCP_CLKSEL_LSB 10
`define CCP_ISEL_LSB 5
`define CCP_FAULT_INPUT_ENABLE_LSB 13
`define CCP_SYNC_LSB 0
`define CCP_TRIGMODE_BIT 7
`define CCP_TRIGGER_ENABLE_BIT 8
`define CCP_SSA_LSB 2
`define CCP_SSB_LSB 0
`define CCP_STEER_LSB 8
`define CCP_OSC_LSB 12
`define CCP_OUTPUT_TRIGGER_GATE_BIT 15
// Reset values
`define CCP_RESET_WORD 16'h0000
`define CCP_SELF_SYNC 5'h1f
`define CCP_PSS_ACTIVE 2'h3
`define CCP_PSS_INACTIVE 2'h2
`define CCP_READ_UNMAPPED 32'h0000_0000
`endif

// *** hw/ccp_pkg.sv ***
// Types shared by the capture/compare/PWM unit
package ccp_pkg;
  typedef enum logic [3:0] {
    MODE_TIMER = 4'h0, MODE_SET_HIGH = 4'h1, MODE_SET_LOW = 4'h2, MODE_TOGGLE = 4'h3,
    MODE_DUAL = 4'h4, MODE_DUAL_BUF = 4'h5, MODE_CENTRE = 4'h6, MODE_VFREQ = 4'h7,
    MODE_EXT = 4'hf
  } compare_mode_e;
  typedef struct packed {
    logic [3:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
  } bus_req_s;
  typedef struct packed {
    logic [5:0] pin_out;
    logic [5:0] pin_oe;
  } pin_drive_s;
endpackage : ccp_pkg

// *** hw/ccp_edge_detect.sv ***
// Edge detector and prescaled event counter for capture input
`timescale 1ns/1ps
module ccp_edge_detect (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_srst,
  // Control
  input wire logic [3:0] i_mode,
  input wire logic i_enable,
  input wire logic i_level,
  // Event
  output logic o_event
);
  logic last_level;
  logic [3:0] edge_count;
  logic next_last_level;
  logic [3:0] next_edge_count;
  logic rise;
  logic fall;

  // Event selection by mode, reserved codes never fire
  always_comb begin
    rise = i_level & ~last_level;
    fall = ~i_level & last_level;
    next_last_level = i_level;
    next_edge_count = edge_count;
    o_event = 1'b0;
    if (i_enable) begin
      unique case (i_mode)
        4'h0, 4'h3: o_event = rise | fall;
        4'h1: o_event = rise;
        4'h2: o_event = fall;
        4'h4, 4'h5: begin
          // Prescaled rising edges counted, wrap at 4 or 16
          if (rise) begin
            next_edge_count = edge_count + 4'h1;
            o_event = (i_mode == 4'h4) ? (edge_count[1:0] == 2'h3) : (edge_count == 4'hf);
          end
        end
        default: o_event = 1'b0;
      endcase
    end else begin
      next_edge_count = 4'h0;
    end
  end

  // State registers
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      last_level <= 1'b0;
      edge_count <= 4'h0;
    end else begin
      last_level <= next_last_level;
      edge_count <= next_edge_count;
    end
  end
endmodule : ccp_edge_detect

// *** hw/ccp_output_steer.sv ***
// Output steering, polarity-free shutdown handling and pin enables
`timescale 1ns/1ps
`include "ccp_consts.svh"
module ccp_output_steer (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_srst,
  // Controls
  input wire logic [2:0] i_steer,
  input wire logic [1:0] i_ss_a,
  input wire logic [1:0] i_ss_b,
  input wire logic i_shutdown,
  input wire logic i_gate,
  input wire logic i_wave,
  input wire logic i_active,
  // Pins
  output ccp_pkg::pin_drive_s o_pins
);
  ccp_pkg::pin_drive_s next_pins;
  logic [5:0] pattern;

  // Steering per mode, group A = pins 0,2,4, group B = 1,3,5
  always_comb begin
    pattern = 6'h00;
    unique case (i_steer)
      3'h0: pattern = {5'h00, i_wave};
      3'h1: pattern = {4'h0, ~i_wave, i_wave};
      3'h2: pattern = {4'h0, ~i_wave, i_wave};
      3'h4: pattern = {2'h0, i_wave, 3'h0};
      3'h5: pattern = {5'h00, i_wave};
      3'h6: pattern = {6{i_wave}};
      default: pattern = 6'h00;
    endcase
    // Idle, capture and reserved modes keep all pins low with their enables off
    next_pins.pin_out = i_active ? pattern : 6'h00;
    next_pins.pin_oe = i_active ? 6'h3f : 6'h00;
    if (i_shutdown) begin
      // Per-group shutdown states; high impedance just drops the enable
      for (int g = 0; g < 6; g++) begin
        if ((g % 2) == 0) begin
          next_pins.pin_out[g] = (i_ss_a == `CCP_PSS_ACTIVE);
          next_pins.pin_oe[g] = i_ss_a[1];
        end else begin
          next_pins.pin_out[g] = (i_ss_b == `CCP_PSS_ACTIVE);
          next_pins.pin_oe[g] = i_ss_b[1];
        end
      end
    end else if (!i_gate) begin
      next_pins.pin_oe = 6'h00;
      next_pins.pin_out = 6'h00;
    end
  end

  // Pins come from flops
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_pins <= '0;
    end else begin
      o_pins <= next_pins;
    end
  end
endmodule : ccp_output_steer

// *** hw/capture_compare_pwm_unit.sv ***
// Capture/compare/PWM unit with Avalon-MM register slave
`timescale 1ns/1ps
`include "ccp_consts.svh"
module capture_compare_pwm_unit (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_srst,
  // Avalon-MM slave
  input wire logic [3:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // Clock sources: one-cycle tick pulses, index 0 is the core clock
  input wire logic [7:0] i_clock_ticks,
  // Capture, external and trigger inputs
  input wire logic i_capture_in,
  input wire logic [7:0] i_external_sources,
  input wire logic [31:0] i_sync_sources,
  input wire logic [2:0] i_fault_in,
  // Output pins
  output logic [5:0] o_pin,
  output logic [5:0] o_pin_oe,
  // Event pulse
  output logic o_compare_event
);
  // Registers
  logic [15:0] ccp_control_one_low;
  logic [15:0] ccp_output_control_high;
  logic [15:0] compare_control_two;
  logic [15:0] primary_compare_value;
  logic [15:0] secondary_compare_value;
  logic [15:0] shadow_duty;
  logic [15:0] shadow_period;
  logic [15:0] timer;
  logic [15:0] capture_value;
  logic wave;
  logic armed;
  logic triggered;
  logic fault_latched;
  logic [2:0] extend_left;
  logic bus_done;
  logic [31:0] readdata;
  logic next_bus_done;
  logic [31:0] next_readdata;
  logic [15:0] next_control_one;
  logic [15:0] next_output_control;
  logic [15:0] next_control_two;
  logic [15:0] next_primary;
  logic [15:0] next_secondary;
  logic [15:0] next_shadow_duty;
  logic [15:0] next_shadow_period;
  logic [15:0] next_timer;
  logic [15:0] next_capture_value;
  logic next_wave;
  logic next_armed;
  logic next_triggered;
  logic next_fault_latched;
  logic [2:0] next_extend_left;
  logic next_compare_event;
  logic compare_event;
  // Decoded fields
  logic [3:0] mode;
  logic capture_function_select;
  logic [2:0] compare_clock_select;
  logic [2:0] external_input_select;
  logic [2:0] fault_input_enable;
  logic [4:0] sync_source_select;
  logic trigger_mode_bit;
  logic trigger_enable;
  logic output_trigger_gate;
  logic [2:0] one_shot_extend_count;
  logic [2:0] output_steering_mode;
  logic [1:0] shutdown_state_group_a;
  logic [1:0] shutdown_state_group_b;
  logic tick;
  logic capture_event;
  logic sync_hit;
  logic period_end;
  logic shutdown;
  logic out_active;
  logic reserved_mode;
  ccp_pkg::pin_drive_s pins;
  ccp_pkg::bus_req_s req;

  // Field decode
  assign mode = ccp_control_one_low[`CCP_MODE_LSB +: 4];
  assign capture_function_select = ccp_control_one_low[`CCP_CAPSEL_BIT];
  assign compare_clock_select = ccp_control_one_low[`CCP_CLKSEL_LSB +: 3];
  assign external_input_select = ccp_control_one_low[`CCP_ISEL_LSB +: 3];
  assign fault_input_enable = ccp_control_one_low[`CCP_FAULT_INPUT_ENABLE_LSB +: 3];
  assign sync_source_select = compare_control_two[`CCP_SYNC_LSB +: 5];
  assign trigger_mode_bit = compare_control_two[`CCP_TRIGMODE_BIT];
  assign trigger_enable = compare_control_two[`CCP_TRIGGER_ENABLE_BIT];
  assign output_trigger_gate = ccp_output_control_high[`CCP_OUTPUT_TRIGGER_GATE_BIT];
  assign one_shot_extend_count = ccp_output_control_high[`CCP_OSC_LSB +: 3];
  assign output_steering_mode = ccp_output_control_high[`CCP_STEER_LSB +: 3];
  assign shutdown_state_group_a = ccp_output_control_high[`CCP_SSA_LSB +: 2];
  assign shutdown_state_group_b = ccp_output_control_high[`CCP_SSB_LSB +: 2];
  assign req = '{address: i_avs_address, read: i_avs_read, write: i_avs_write, writedata: i_avs_writedata};

  // Counting tick from selected prescaler pulse, never the timer's rollover
  assign tick = i_clock_ticks[compare_clock_select];
  // Self-sync resets on own period; otherwise the chosen source
  assign sync_hit = (sync_source_select == `CCP_SELF_SYNC) ? (timer >= shadow_period)
                    : i_sync_sources[sync_source_select];
  assign period_end = tick & sync_hit;
  assign shutdown = |(i_fault_in & fault_input_enable) | fault_latched;
  assign reserved_mode = ~capture_function_select & (mode[3] & (mode != 4'hf));
  assign out_active = ~capture_function_select & (mode != 4'h0) & ~reserved_mode;

  // Capture event engine
  ccp_edge_detect u_edge (
    .i_core_clk(i_core_clk),
    .i_srst(i_srst),
    .i_mode(mode),
    .i_enable(capture_function_select),
    .i_level(i_capture_in),
    .o_event(capture_event)
  );

  // Bus slave: one wait cycle then answer; unmapped reads zero
  always_comb begin
    next_bus_done = (req.read | req.write) & ~bus_done;
    next_readdata = readdata;
    next_control_one = ccp_control_one_low;
    next_output_control = ccp_output_control_high;
    next_control_two = compare_control_two;
    next_primary = primary_compare_value;
    next_secondary = secondary_compare_value;
    if (req.read & ~bus_done) begin
      unique case (req.address)
        `CCP_OFS_CONTROL_ONE_LOW: next_readdata = {16'h0000, ccp_control_one_low};
        `CCP_OFS_OUTPUT_CONTROL_HIGH: next_readdata = {16'h0000, ccp_output_control_high & 16'hf73f};
        `CCP_OFS_COMPARE_CONTROL_TWO: next_readdata = {16'h0000, compare_control_two};
        `CCP_OFS_PRIMARY_COMPARE: next_readdata = {16'h0000, primary_compare_value};
        `CCP_OFS_SECONDARY_COMPARE: next_readdata = {16'h0000, secondary_compare_value};
        `CCP_OFS_STATUS: next_readdata = {27'h0, shutdown, triggered, armed, wave, compare_event};
        `CCP_OFS_CAPTURE: next_readdata = {16'h0000, capture_value};
        `CCP_OFS_TIMER: next_readdata = {16'h0000, timer};
        default: next_readdata = `CCP_READ_UNMAPPED;
      endcase
    end
    if (req.write & ~bus_done) begin
      unique case (req.address)
        // Unused bits are not stored, so they read back as zero
        `CCP_OFS_CONTROL_ONE_LOW: next_control_one = req.writedata[15:0] & 16'hfcff;
        `CCP_OFS_OUTPUT_CONTROL_HIGH: next_output_control = req.writedata[15:0] & 16'hf73f;
        `CCP_OFS_COMPARE_CONTROL_TWO: next_control_two = req.writedata[15:0] & 16'h019f;
        `CCP_OFS_PRIMARY_COMPARE: next_primary = req.writedata[15:0];
        `CCP_OFS_SECONDARY_COMPARE: next_secondary = req.writedata[15:0];
        default: next_primary = primary_compare_value;
      endcase
    end
  end

  // Timer, shadows, waveform and one-shot state
  always_comb begin
    next_timer = timer;
    next_shadow_duty = shadow_duty;
    next_shadow_period = shadow_period;
    next_capture_value = capture_value;
    next_wave = wave;
    next_armed = armed;
    next_triggered = triggered;
    next_extend_left = extend_left;
    next_compare_event = 1'b0;
    next_fault_latched = fault_latched | |(i_fault_in & fault_input_enable);
    if (req.write & ~bus_done & (req.address == `CCP_OFS_CONTROL_ONE_LOW)) begin
      // A fault in the rearm cycle still latches: set wins over clear
      next_fault_latched = |(i_fault_in & fault_input_enable);
      next_armed = 1'b1;
      next_triggered = 1'b0;
    end
    // Trigger arrives from selected source when triggered mode chosen
    if (trigger_mode_bit & trigger_enable & i_sync_sources[sync_source_select]) begin
      next_triggered = 1'b1;
    end
    if (capture_event) begin
      next_capture_value = timer;
      next_compare_event = 1'b1;
    end
    if (tick) begin
      next_timer = timer + 16'h0001;
      if (period_end) begin
        next_timer = 16'h0000;
        // Shadows only reload at period boundary
        next_shadow_duty = primary_compare_value;
        next_shadow_period = secondary_compare_value;
        if (extend_left != 3'h0) begin
          next_extend_left = extend_left - 3'h1;
        end
      end
      if (!capture_function_select) begin
        unique case (mode)
          // Set and clear are single-shot; toggle keeps running every match
          4'h1, 4'h2, 4'h3: if ((armed || mode == 4'h3) && timer == primary_compare_value) begin
            next_compare_event = 1'b1;
            next_armed = 1'b0;
            next_wave = (mode == 4'h1) ? 1'b1 : (mode == 4'h2) ? 1'b0 : ~wave;
          end
          4'h4: begin
            // Unbuffered dual edge uses live registers
            if (timer == primary_compare_value) next_wave = 1'b1;
            if (timer == secondary_compare_value) begin
              next_wave = 1'b0;
              next_compare_event = 1'b1;
            end
          end
          4'h5: begin
            // Edge-aligned PWM from shadows
            if (period_end) next_wave = 1'b1;
            else if (timer == shadow_duty && extend_left == 3'h0) begin
              next_wave = 1'b0;
              next_compare_event = 1'b1;
              next_extend_left = one_shot_extend_count;
            end
          end
          4'h6: begin
            // Centre-aligned: high between duty and period minus duty
            next_wave = (timer >= shadow_duty) && (timer < shadow_period - shadow_duty);
            next_compare_event = period_end;
          end
          4'h7: if (timer == shadow_duty) begin
            next_timer = 16'h0000;
            next_wave = ~wave;
            next_compare_event = 1'b1;
          end
          4'hf: next_wave = i_external_sources[external_input_select];
          default: next_wave = 1'b0;
        endcase
      end
    end
    if (capture_function_select | reserved_mode) begin
      next_wave = 1'b0;
    end
  end

  // Register update
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      bus_done <= 1'b0;
      readdata <= 32'h0;
      ccp_control_one_low <= `CCP_RESET_WORD;
      ccp_output_control_high <= `CCP_RESET_WORD;
      compare_control_two <= `CCP_RESET_WORD;
      primary_compare_value <= `CCP_RESET_WORD;
      secondary_compare_value <= `CCP_RESET_WORD;
      shadow_duty <= `CCP_RESET_WORD;
      shadow_period <= `CCP_RESET_WORD;
      timer <= `CCP_RESET_WORD;
      capture_value <= `CCP_RESET_WORD;
      wave <= 1'b0;
      armed <= 1'b0;
      triggered <= 1'b0;
      fault_latched <= 1'b0;
      extend_left <= 3'h0;
      compare_event <= 1'b0;
    end else begin
      bus_done <= next_bus_done;
      readdata <= next_readdata;
      ccp_control_one_low <= next_control_one;
      ccp_output_control_high <= next_output_control;
      compare_control_two <= next_control_two;
      primary_compare_value <= next_primary;
      secondary_compare_value <= next_secondary;
      shadow_duty <= next_shadow_duty;
      shadow_period <= next_shadow_period;
      timer <= next_timer;
      capture_value <= next_capture_value;
      wave <= next_wave;
      armed <= next_armed;
      triggered <= next_triggered;
      fault_latched <= next_fault_latched;
      extend_left <= next_extend_left;
      compare_event <= next_compare_event;
    end
  end

  // Output stage; fault interrupt left to software
  ccp_output_steer u_steer (
    .i_core_clk(i_core_clk),
    .i_srst(i_srst),
    .i_steer(output_steering_mode),
    .i_ss_a(shutdown_state_group_a),
    .i_ss_b(shutdown_state_group_b),
    .i_shutdown(shutdown & out_active),
    .i_gate(~(output_trigger_gate & trigger_mode_bit) | triggered),
    .i_wave(wave),
    .i_active(out_active),
    .o_pins(pins)
  );

  assign o_pin = pins.pin_out;
  assign o_pin_oe = pins.pin_oe;
  assign o_compare_event = compare_event;
  assign o_avs_readdata = readdata;
  // Waitrequest high until the answer cycle
  assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~bus_done;
endmodule : capture_compare_pwm_unit

// *** dv/ccp_far_side.sv ***
// Far-side model: timer prescaler ticks and pin-side sources
`timescale 1ns/1ps
module ccp_far_side (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_srst,
  // Levels chosen by the bench
  input wire logic i_cap_lvl,
  input wire logic [31:0] i_sync_lvl,
  input wire logic [2:0] i_fault_lvl,
  // Sources into the unit
  output logic [7:0] o_clock_ticks,
  output logic o_capture_in,
  output logic [7:0] o_external_sources,
  output logic [31:0] o_sync_sources,
  output logic [2:0] o_fault_in
);
  logic [7:0] pre = 8'h00;
  logic [7:0] next_pre;
  // Free-running prescaler shared by all timers
  always_comb begin
    next_pre = i_srst ? 8'h00 : pre + 8'h01;
  end
  always_ff @(posedge i_core_clk) begin
    pre <= next_pre;
  end
  // Source k gives one prescaler pulse every k+1 cycles, never a timer output
  always_comb begin
    for (int k = 0; k < 8; k++) begin
      o_clock_ticks[k] = (pre % (k + 1)) == 0;
    end
  end
  // External sources keep changing so a followed source is visible
  assign o_external_sources = {8{pre[1]}} ^ 8'h55;
  assign o_capture_in = i_cap_lvl;
  assign o_sync_sources = i_sync_lvl;
  assign o_fault_in = i_fault_lvl;
endmodule : ccp_far_side

// *** dv/ccp_monitor.sv ***
// Bus and pin checker for the capture/compare/PWM unit
`timescale 1ns/1ps
module ccp_monitor (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_srst,
  // Bus
  input wire logic [3:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [31:0] o_avs_readdata,
  input wire logic o_avs_waitrequest,
  // Pins
  input wire logic [5:0] o_pin,
  input wire logic [5:0] o_pin_oe,
  input wire logic o_compare_event
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_srst);
  logic [4:0][15:0] shadow, next_shadow;
  logic [3:0] age, next_age;
  function automatic logic [15:0] wmask(input logic [2:0] a);
    case (a)
      3'h0: wmask = 16'hfcff;
      3'h1: wmask = 16'hf73f;
      3'h2: wmask = 16'h019f;
      default: wmask = 16'hffff;
    endcase
  endfunction : wmask
  // Shadow of accepted writes; age counts settle time after any write to registers 0 to 4
  always_comb begin
    next_shadow = shadow;
    next_age = (age == 4'hf) ? age : age + 4'h1;
    if (i_avs_write && !o_avs_waitrequest && i_avs_address < 4'h5) begin
      next_shadow[i_avs_address[2:0]] = i_avs_writedata[15:0] & wmask(i_avs_address[2:0]);
      next_age = 4'h0;
    end
  end
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      shadow <= '0;
      age <= 4'h0;
    end else begin
      shadow <= next_shadow;
      age <= next_age;
    end
  end
  sequence seq_pending;
    (i_avs_read || i_avs_write) && o_avs_waitrequest;
  endsequence
  sequence seq_read_done;
    i_avs_read && !o_avs_waitrequest;
  endsequence
  chk_wait_on_start: assert property ($rose(i_avs_read || i_avs_write) |-> o_avs_waitrequest)
    else $error("waitrequest low on a fresh request");
  chk_answer_one_cycle: assert property (seq_pending ##1 (i_avs_read || i_avs_write) |-> !o_avs_waitrequest)
    else $error("answer not one cycle after request");
  chk_upper_zero: assert property (o_avs_readdata[31:16] == 16'h0000)
    else $error("upper read data not zero");
  chk_data_holds: assert property (!(i_avs_read && o_avs_waitrequest) |=> $stable(o_avs_readdata))
    else $error("read data changed without a read");
  chk_unmapped_zero: assert property (seq_read_done and i_avs_address[3] |-> o_avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  chk_readback_match: assert property (seq_read_done and (i_avs_address < 4'h5)
    |-> o_avs_readdata[15:0] == shadow[i_avs_address[2:0]])
    else $error("register read back differs");
  chk_reset_quiet: assert property (disable iff (1'b0)
    i_srst |=> o_pin == 6'h00 && o_pin_oe == 6'h00 && !o_compare_event)
    else $error("outputs active after reset");
  chk_timer_pins_off: assert property (age == 4'hf && shadow[0][4:0] == 5'h00 && shadow[0][15:13] == 3'h0
    |-> o_pin_oe == 6'h00)
    else $error("timer mode drives pins");
  chk_reserved_low: assert property (age == 4'hf && !shadow[0][4] && shadow[0][3] && shadow[0][3:0] != 4'hf
    && shadow[0][15:13] == 3'h0 |-> o_pin == 6'h00)
    else $error("reserved mode drives pins high");
endmodule : ccp_monitor
bind capture_compare_pwm_unit ccp_monitor u_mon (.i_core_clk(i_core_clk), .i_srst(i_srst),
  .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
  .i_avs_writedata(i_avs_writedata), .o_avs_readdata(o_avs_readdata),
  .o_avs_waitrequest(o_avs_waitrequest), .o_pin(o_pin), .o_pin_oe(o_pin_oe),
  .o_compare_event(o_compare_event));

// *** dv/testbench.sv ***
// Self-checking bench for the capture/compare/PWM unit
`timescale 1ns/1ps
module testbench;
  logic i_core_clk = 1'b0;
  logic i_srst = 1'b1;
  ccp_pkg::bus_req_s req = '0;
  logic [31:0] rdata, rd32, sync, sync_lvl = '0;
  logic [7:0] ticks, ext;
  logic [5:0] pin, oe, last_pin = '0;
  logic [2:0] flt, flt_lvl = '0;
  logic wreq, evt, cap, cap_lvl = 1'b0;
  logic [15:0] d;
  logic [3:0] modes [10] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'hf, 4'hb};
  int mismatches = 0, n_compared = 0, n_evt = 0, n_tog = 0, t0, t3, cyc = 0;
  // Clock
  always #5 i_core_clk = ~i_core_clk;
  // Event and pin-change counters, sampled race-free
  always @(posedge i_core_clk) begin
    n_evt <= n_evt + evt;
    n_tog <= n_tog + (pin != last_pin);
    last_pin <= pin;
    // Core ticks since reset; tracks the free-running timer while idle
    cyc <= i_srst ? 0 : cyc + 1;
  end
  capture_compare_pwm_unit uut (.i_core_clk(i_core_clk), .i_srst(i_srst), .i_avs_address(req.address),
    .i_avs_read(req.read), .i_avs_write(req.write), .i_avs_writedata(req.writedata),
    .o_avs_readdata(rdata), .o_avs_waitrequest(wreq), .i_clock_ticks(ticks), .i_capture_in(cap),
    .i_external_sources(ext), .i_sync_sources(sync), .i_fault_in(flt), .o_pin(pin), .o_pin_oe(oe),
    .o_compare_event(evt));
  ccp_far_side far (.i_core_clk(i_core_clk), .i_srst(i_srst), .i_cap_lvl(cap_lvl), .i_sync_lvl(sync_lvl),
    .i_fault_lvl(flt_lvl), .o_clock_ticks(ticks), .o_capture_in(cap), .o_external_sources(ext),
    .o_sync_sources(sync), .o_fault_in(flt));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : test_done
  // One Avalon access; held until waitrequest is sampled low
  task automatic bus(input logic [3:0] a, input logic w, input logic [15:0] wd);
    int n;
    n = 0;
    req <= '{a, !w, w, {16'h0, wd}};
    do begin
      @(posedge i_core_clk);
      n++;
    end while (wreq !== 1'b0 && n < 100);
    rd32 = rdata;
    if (n >= 100) begin
      mismatches++;
      test_done();
    end else begin
      req <= '0;
      @(posedge i_core_clk);
    end
  endtask : bus
  function automatic logic [15:0] msk(input int a);
    case (a)
      0: msk = 16'hfcff;
      1: msk = 16'hf73f;
      2: msk = 16'h019f;
      3, 4: msk = 16'hffff;
      default: msk = 16'h0000;
    endcase
  endfunction : msk
  function automatic logic exp_tog(input logic [3:0] m);
    exp_tog = (m >= 4'h3 && m <= 4'h7) || m == 4'hf;
  endfunction : exp_tog
  function automatic int exp_cap(input int m);
    exp_cap = (m == 0 || m == 3) ? 32 : (m == 4) ? 4 : (m == 5) ? 1 : 16;
  endfunction : exp_cap
  // Shutdown levels: even pins group A, odd pins group B
  function automatic logic [11:0] exp_ss(input logic [1:0] sa, input logic [1:0] sb);
    logic [1:0] g;
    for (int k = 0; k < 6; k++) begin
      g = k[0] ? sb : sa;
      exp_ss[k + 6] = g == 2'h3;
      exp_ss[k] = g[1];
    end
  endfunction : exp_ss
  // Main sequence
  initial begin
    d = 16'($urandom(32'h6aab0411));
    repeat (2) @(posedge i_core_clk);
    i_srst <= 1'b0;
    @(posedge i_core_clk);
    // Reset contents and the unmapped range
    for (int a = 0; a < 16; a++) begin
      bus(4'(a), 1'b0, 16'h0);
      // Timer was sampled two edges before the bench looks
      check(rd32, (a == 7) ? 32'(cyc - 2) : 32'h0);
    end
    // Random readback with stray unmapped writes between
    repeat (4) for (int a = 0; a < 5; a++) begin
      d = 16'($urandom);
      bus(4'(a), 1'b1, d);
      bus(4'h9, 1'b1, ~d);
      bus(4'(a), 1'b0, 16'h0);
      check(rd32, {16'h0, d & msk(a)});
    end
    // Every steering and one-shot code is held
    for (int s = 0; s < 8; s++) begin
      bus(4'h1, 1'b1, 16'(s << 8 | s << 12));
      bus(4'h1, 1'b0, 16'h0);
      check(rd32, 32'(s << 8 | s << 12));
    end
    // Mid-run reset drops random periods left by the readback runs
    i_srst <= 1'b1;
    repeat (2) @(posedge i_core_clk);
    i_srst <= 1'b0;
    @(posedge i_core_clk);
    // Compare modes with self-sync, duty then period first
    foreach (modes[i]) begin
      bus(4'h3, 1'b1, 16'(1 + $urandom % 3));
      bus(4'h4, 1'b1, 16'(6 + $urandom % 4));
      bus(4'h2, 1'b1, 16'h001f);
      bus(4'h1, 1'b1, 16'h0000);
      bus(4'h0, 1'b1, {12'h002, modes[i]});
      repeat (20) @(posedge i_core_clk);
      t0 = n_tog;
      repeat (40) @(posedge i_core_clk);
      check(32'(n_tog > t0), 32'(exp_tog(modes[i])));
      if (modes[i] == 4'h3) t3 = n_tog - t0;
      if (modes[i] == 4'h0) check(32'(oe), 32'h0);
      if (modes[i] == 4'h1 || modes[i] == 4'h2) check(32'(|(pin & oe)), 32'(modes[i] == 4'h1));
    end
    // Slower prescaled clock gives fewer toggles
    bus(4'h0, 1'b1, 16'h0c03);
    repeat (20) @(posedge i_core_clk);
    t0 = n_tog;
    repeat (40) @(posedge i_core_clk);
    check(32'(n_tog - t0 < t3), 32'h1);
    // Capture event kinds over 16 input pulses
    for (int m = 0; m < 6; m++) begin
      bus(4'h0, 1'b1, 16'(16'h0010 | m));
      repeat (5) @(posedge i_core_clk);
      t0 = n_evt;
      repeat (16) begin
        cap_lvl <= 1'b1;
        repeat (6) @(posedge i_core_clk);
        cap_lvl <= 1'b0;
        repeat (6) @(posedge i_core_clk);
      end
      repeat (10) @(posedge i_core_clk);
      check(32'(n_evt - t0), 32'(exp_cap(m)));
    end
    // Trigger gate holds pins until the chosen source rises
    bus(4'h1, 1'b1, 16'h8000);
    bus(4'h2, 1'b1, 16'h0185);
    bus(4'h0, 1'b1, 16'h0001);
    repeat (30) @(posedge i_core_clk);
    check(32'(oe), 32'h0);
    sync_lvl <= 32'h0000_0020;
    repeat (30) @(posedge i_core_clk);
    check(32'(oe != 6'h00), 32'h1);
    sync_lvl <= '0;
    // Shutdown on a fault, each state in both groups over four pairs
    for (int i = 0; i < 4; i++) begin
      bus(4'h1, 1'b1, 16'(i << 2 | (3 - i)));
      bus(4'h2, 1'b1, 16'h001f);
      bus(4'h0, 1'b1, 16'h2004);
      flt_lvl <= 3'h1;
      repeat (20) @(posedge i_core_clk);
      check({20'h0, pin, oe}, {20'h0, exp_ss(2'(i), 2'(3 - i))});
      flt_lvl <= 3'h0;
      bus(4'h0, 1'b1, 16'h0000);
    end
    test_done();
  end
endmodule : testbench
